/* File: verilog/rtc_irq_regs.sv */
/*
  Interrupt enable, interrupt flag, sync status, run-in-debug and frequency
  trim registers of a real-time counter, with the counter-clock tick divider,
  behind an AXI4-Lite slave. Assumes the counting datapath presents its events
  in the cycle in which counter_clock_o is high, and that mode, software reset
  and sync requests come from the control register outside this block.
*/
// Added by the designer: register access over AXI4-Lite.
// Summary of operation
// - In 16-bit mode a one written to a compare enable-set bit turns that enable on, a zero does nothing.
// - In calendar mode enable-set bits 7, 6 and 0 are overflow, sync-ready and alarm, set by ones, reset to zero.
// - The overflow flag rises on the counter tick after an overflow, in every mode.
// - The interrupt request is high in the cycle after some flag and its enable are both one.
// - Compare flags rise on the tick after a match: channel 0 in 32-bit mode, channels 0 and 1 in 16-bit mode.
// - In calendar mode the alarm flag, bit 0, rises on the tick after an alarm match.
// - The sync-ready flag rises when sync-in-progress falls, unless that sync came from enable or software reset.
// - Each flag clears when a one is written to it, a zero does nothing, and reset is zero.
// - Sync-in-progress, status bit 7, is one from the start of a register sync until it completes.
// - With run-in-debug zero the counter halts in debug mode; with it one, counting goes on.
// - A software reset leaves run-in-debug unchanged.
// - Trim sign zero lowers the counter frequency, one raises it.
// - Trim magnitude zero leaves the prescaler unchanged; 1 to 127 adjust it by that many ticks in 128.
// - A one written to the enable-clear register clears that enable, a zero does nothing.
`timescale 1ns/1ps
`include "rtc_defs.svh"

module rtc_irq_regs #(
  parameter int ADDR_W  = 12,
  parameter int CNT_DIV = `RTC_CNT_DIV
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire rtc_pkg::rtc_mode_t mode_i,
  input  wire rtc_pkg::rtc_evt_t  events_i,
  input  wire logic              swrst_i,
  input  wire logic              sync_start_i,
  input  wire logic              sync_quiet_i,
  input  wire logic              dbg_halt_i,
  output logic                   counter_clock_o,
  output logic                   irq_o
);
  import rtc_pkg::*;

  // ----------------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------------
  function automatic logic [7:0] mode_mask(input rtc_mode_t m);
    case (m)
      RTC_COUNT16_MODE: mode_mask = 8'hc3;
      default:          mode_mask = 8'hc1;
    endcase
  endfunction : mode_mask

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
    reg_hit = (a[ADDR_W-1:10] == '0) && (a[1:0] == 2'h0) && (a[9:2] inside {`RTC_IDX_ENCLR,
              `RTC_IDX_ENSET, `RTC_IDX_FLAG, `RTC_IDX_STATUS, `RTC_IDX_DEBUG, `RTC_IDX_TRIM});
  endfunction : reg_hit

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic              aw_full_q, aw_full_d, w_full_q, w_full_d;
  logic [ADDR_W-1:0] aw_addr_q, aw_addr_d;
  logic [7:0]        w_data_q, w_data_d;
  logic              w_lo_q, w_lo_d;
  logic              awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
  logic [1:0]        bresp_d, rresp_d;
  logic [31:0]       rdata_d;
  logic [7:0]        en_q, en_d, flags_q, flags_d, dbg_q, dbg_d;
  logic [7:0]        trim_q, trim_d, trim_act_q, trim_act_d;
  logic              busy_q, busy_d, quiet_q, quiet_d, irq_d;
  logic [3:0]        sync_cnt_q, sync_cnt_d;
  logic [7:0]        div_q, div_d, lim, mask, flag_set, flag_clr, wr_idx;
  logic [6:0]        phase_q, phase_d;
  logic              tick_d, run, wr_do, wr_lo, sync_done;
  rtc_evt_t          pend_q, pend_d;

  assign mask      = mode_mask(mode_i);
  assign wr_do     = aw_full_q & w_full_q & ~bvalid;
  assign wr_idx    = aw_addr_q[9:2];
  assign wr_lo     = wr_do & w_lo_q & reg_hit(aw_addr_q);
  assign sync_done = busy_q & (sync_cnt_q == 4'h0);

  // ----------------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------------
  always_comb begin
    aw_full_d = aw_full_q;
    aw_addr_d = aw_addr_q;
    w_full_d  = w_full_q;
    w_data_d  = w_data_q;
    w_lo_d    = w_lo_q;
    bvalid_d  = bvalid;
    bresp_d   = bresp;
    rvalid_d  = rvalid;
    rresp_d   = rresp;
    rdata_d   = rdata;
    if (awvalid && awready) begin
      aw_full_d = 1'b1;
      aw_addr_d = awaddr;
    end
    if (wvalid && wready) begin
      w_full_d = 1'b1;
      w_data_d = wdata[7:0];
      w_lo_d   = wstrb[0];
    end
    if (wr_do) begin
      aw_full_d = 1'b0;
      w_full_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = reg_hit(aw_addr_q) ? 2'h0 : 2'h2;
    end else if (bvalid && bready) begin
      bvalid_d = 1'b0;
    end
    if (arvalid && arready) begin
      rvalid_d = 1'b1;
      rresp_d  = reg_hit(araddr) ? 2'h0 : 2'h2;
      case (reg_hit(araddr) ? araddr[9:2] : 8'hff)
        `RTC_IDX_ENCLR, `RTC_IDX_ENSET: rdata_d = {24'h0, en_q & mask};
        `RTC_IDX_FLAG:   rdata_d = {24'h0, flags_q & mask};
        `RTC_IDX_STATUS: rdata_d = {24'h0, busy_q, 7'h00};
        `RTC_IDX_DEBUG:  rdata_d = {24'h0, dbg_q};
        `RTC_IDX_TRIM:   rdata_d = {24'h0, trim_q};
        default:         rdata_d = 32'h0;
      endcase
    end else if (rvalid && rready) begin
      rvalid_d = 1'b0;
    end
    awready_d = ~aw_full_d & ~bvalid_d;
    wready_d  = ~w_full_d & ~bvalid_d;
    arready_d = ~rvalid_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= '0;
      w_full_q  <= 1'b0;
      w_data_q  <= 8'h00;
      w_lo_q    <= 1'b0;
      awready   <= 1'b0;
      wready    <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= 2'h0;
      arready   <= 1'b0;
      rvalid    <= 1'b0;
      rresp     <= 2'h0;
      rdata     <= 32'h0;
    end else begin
      aw_full_q <= aw_full_d;
      aw_addr_q <= aw_addr_d;
      w_full_q  <= w_full_d;
      w_data_q  <= w_data_d;
      w_lo_q    <= w_lo_d;
      awready   <= awready_d;
      wready    <= wready_d;
      bvalid    <= bvalid_d;
      bresp     <= bresp_d;
      arready   <= arready_d;
      rvalid    <= rvalid_d;
      rresp     <= rresp_d;
      rdata     <= rdata_d;
    end
  end

  // ----------------------------------------------------------------------
  // Enables, flags, sync status, debug and trim
  // ----------------------------------------------------------------------
  always_comb begin
    flag_set = 8'h00;
    flag_set[`RTC_BIT_OVERFLOW]   = counter_clock_o & pend_q.overflow;
    flag_set[`RTC_BIT_SYNC_READY] = sync_done & ~quiet_q;
    flag_set[`RTC_BIT_MATCH1]     = counter_clock_o & pend_q.compare_match_x[1];
    flag_set[`RTC_BIT_MATCH0]     = counter_clock_o & ((mode_i == RTC_CALENDAR_MODE) ?
                                 pend_q.alarm_match_zero :
                                 pend_q.compare_match_x[0]);
    flag_clr = (wr_lo && wr_idx == `RTC_IDX_FLAG) ? w_data_q : 8'h00;
    en_d       = en_q;
    dbg_d      = dbg_q;
    trim_d     = trim_q;
    trim_act_d = trim_act_q;
    busy_d     = busy_q;
    quiet_d    = quiet_q;
    sync_cnt_d = sync_cnt_q;
    // Set beats clear when both land in one cycle
    flags_d    = (flags_q & ~flag_clr) | (flag_set & mask);
    if (wr_lo && wr_idx == `RTC_IDX_ENSET) begin
      en_d = en_q | (w_data_q & mask);
    end
    if (wr_lo && wr_idx == `RTC_IDX_ENCLR) begin
      en_d = en_q & ~(w_data_q & mask);
    end
    if (wr_lo && wr_idx == `RTC_IDX_DEBUG) begin
      dbg_d = {7'h00, w_data_q[`RTC_BIT_RUN_DEBUG]};
    end
    if (sync_done) begin
      busy_d     = 1'b0;
      trim_act_d = trim_q;
    end else if (busy_q) begin
      sync_cnt_d = sync_cnt_q - 4'h1;
    end
    if (wr_lo && wr_idx == `RTC_IDX_TRIM) begin
      trim_d     = w_data_q;
      busy_d     = 1'b1;
      quiet_d    = 1'b0;
      sync_cnt_d = `RTC_SYNC_CYCLES - 4'h1;
    end else if (sync_start_i) begin
      busy_d     = 1'b1;
      quiet_d    = sync_quiet_i;
      sync_cnt_d = `RTC_SYNC_CYCLES - 4'h1;
    end
    if (swrst_i) begin
      en_d       = `RTC_RST_BYTE;
      flags_d    = `RTC_RST_BYTE;
      trim_d     = `RTC_RST_BYTE;
      trim_act_d = `RTC_RST_BYTE;
      busy_d     = 1'b0;
      quiet_d    = 1'b0;
      sync_cnt_d = 4'h0;
      dbg_d      = dbg_q;
    end
    irq_d = |(flags_q & en_q & mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_q       <= `RTC_RST_BYTE;
      flags_q    <= `RTC_RST_BYTE;
      dbg_q      <= `RTC_RST_BYTE;
      trim_q     <= `RTC_RST_BYTE;
      trim_act_q <= `RTC_RST_BYTE;
      busy_q     <= 1'b0;
      quiet_q    <= 1'b0;
      sync_cnt_q <= 4'h0;
      irq_o      <= 1'b0;
    end else begin
      en_q       <= en_d;
      flags_q    <= flags_d;
      dbg_q      <= dbg_d;
      trim_q     <= trim_d;
      trim_act_q <= trim_act_d;
      busy_q     <= busy_d;
      quiet_q    <= quiet_d;
      sync_cnt_q <= sync_cnt_d;
      irq_o      <= irq_d;
    end
  end

  // ----------------------------------------------------------------------
  // Counter clock prescaler with trim
  // ----------------------------------------------------------------------
  always_comb begin
    run = ~(dbg_halt_i & ~dbg_q[`RTC_BIT_RUN_DEBUG]);
    lim = 8'(CNT_DIV - 1);
    // The first magnitude-many ticks of every 128 are stretched or shortened by a cycle
    if (trim_act_q[6:0] > phase_q) begin
      lim = trim_act_q[`RTC_BIT_SIGN] ? lim - 8'h01 : lim + 8'h01;
    end
    div_d   = div_q;
    phase_d = phase_q;
    tick_d  = 1'b0;
    pend_d  = counter_clock_o ? events_i : pend_q;
    if (run) begin
      if (div_q >= lim) begin
        div_d   = 8'h00;
        tick_d  = 1'b1;
        phase_d = phase_q + 7'h01;
      end else begin
        div_d = div_q + 8'h01;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q           <= 8'h00;
      phase_q         <= 7'h00;
      counter_clock_o <= 1'b0;
      pend_q          <= '0;
    end else begin
      div_q           <= div_d;
      phase_q         <= phase_d;
      counter_clock_o <= tick_d;
      pend_q          <= pend_d;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking chk_cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ovf_flag_set_a: assert property (counter_clock_o && pend_q.overflow && !swrst_i
    |=> flags_q[`RTC_BIT_OVERFLOW]) else $error("overflow flag not set after overflow");
  cmp_flag_set_a: assert property (counter_clock_o && pend_q.compare_match_x[1]
    && mode_i == RTC_COUNT16_MODE && !swrst_i |=> flags_q[`RTC_BIT_MATCH1])
    else $error("compare 1 flag not set after match");
  alarm_flag_set_a: assert property (counter_clock_o && pend_q.alarm_match_zero
    && mode_i == RTC_CALENDAR_MODE && !swrst_i |=> flags_q[`RTC_BIT_MATCH0])
    else $error("alarm flag not set after match");
  irq_gate_a: assert property (##1 irq_o == $past(|(flags_q & en_q & mask)))
    else $error("interrupt request disagrees with flags and enables");
  flag_w1c_a: assert property (flag_clr[`RTC_BIT_OVERFLOW]
    && !flag_set[`RTC_BIT_OVERFLOW] |=> !flags_q[`RTC_BIT_OVERFLOW])
    else $error("overflow flag survived a write of one");
  en_set_a: assert property (wr_lo && wr_idx == `RTC_IDX_ENSET && !swrst_i
    |=> en_q == ($past(en_q) | ($past(w_data_q) & $past(mask))))
    else $error("enable set write wrong");
  en_clr_a: assert property (wr_lo && wr_idx == `RTC_IDX_ENCLR && !swrst_i
    |=> en_q == ($past(en_q) & ~($past(w_data_q) & $past(mask))))
    else $error("enable clear write wrong");
  sync_busy_a: assert property (wr_lo && wr_idx == `RTC_IDX_TRIM && !swrst_i
    |=> busy_q [*4] ##1 !busy_q) else $error("sync busy does not span the sync");
  sync_ready_a: assert property (sync_done && !quiet_q && !swrst_i
    |=> flags_q[`RTC_BIT_SYNC_READY]) else $error("sync ready flag missing after sync");
  dbg_halt_a: assert property (dbg_halt_i && !dbg_q[`RTC_BIT_RUN_DEBUG]
    |=> !counter_clock_o) else $error("counter ticked while halted in debug");
  dbg_keep_a: assert property (swrst_i |=> dbg_q == $past(dbg_q))
    else $error("run in debug lost on software reset");

endmodule : rtc_irq_regs

/* File: verilog/rtc_defs.svh */
/*
  Offsets, field positions, reset values and timing counts of the counter's
  interrupt, status, debug and trim registers. Assumes a 32-bit register bus
  with one aligned word per register: byte address is four times the index.
*/
`ifndef RTC_DEFS_SVH
`define RTC_DEFS_SVH

// ----------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------
`define RTC_IDX_ENCLR   8'h06
`define RTC_IDX_ENSET   8'h07
`define RTC_IDX_FLAG    8'h08
`define RTC_IDX_STATUS  8'h0a
`define RTC_IDX_DEBUG   8'h0b
`define RTC_IDX_TRIM    8'h0c

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define RTC_BIT_OVERFLOW   7
`define RTC_BIT_SYNC_READY 6
`define RTC_BIT_MATCH1     1
`define RTC_BIT_MATCH0     0
`define RTC_BIT_BUSY       7
`define RTC_BIT_RUN_DEBUG  0
`define RTC_BIT_SIGN       7
`define RTC_RST_BYTE       8'h00

// ----------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------
`define RTC_SYNC_CYCLES 4'h4
`define RTC_CNT_DIV     8

`endif

/* File: verilog/rtc_pkg.sv */
/*
  Types shared by the counter register block: counter mode and the bundle of
  counting-datapath events. Assumes nothing of its surroundings.
*/
package rtc_pkg;

  // ----------------------------------------------------------------------
  // Modes and events
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    RTC_COUNT32_MODE,
    RTC_COUNT16_MODE,
    RTC_CALENDAR_MODE
  } rtc_mode_t;

  typedef struct packed {
    logic       overflow;
    logic [1:0] compare_match_x;
    logic       alarm_match_zero;
  } rtc_evt_t;

endpackage : rtc_pkg

/* File: tb/rtc_irq_regs_tb.sv */
/*
  Self-checking bench for the counter interrupt, status, debug and trim
  registers. Assumes the block's AXI4-Lite slave and the tick divider at
  CNT_DIV = 8; the bench drives mode, events, sync and debug inputs itself.
*/
`timescale 1ns/1ps
`include "rtc_defs.svh"

module rtc_irq_regs_tb;
  import rtc_pkg::*;

  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  localparam int DIV = 8;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, counter_clock_o, irq_o;
  logic        swrst_i, sync_start_i, sync_quiet_i, dbg_halt_i;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_q;
  logic [3:0]  wstrb, strb;
  logic [1:0]  bresp, rresp;
  rtc_mode_t   mode_i;
  rtc_evt_t    events_i;
  int          errors, compares;

  rtc_irq_regs #(.ADDR_W(12), .CNT_DIV(DIV)) i_rtc_irq_regs (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .mode_i(mode_i),
    .events_i(events_i), .swrst_i(swrst_i), .sync_start_i(sync_start_i),
    .sync_quiet_i(sync_quiet_i), .dbg_halt_i(dbg_halt_i),
    .counter_clock_o(counter_clock_o), .irq_o(irq_o));

  always #2 aclk = ~aclk;

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    awaddr  <= {2'b00, idx, 2'b00};
    wdata   <= {24'h000000, d};
    wstrb   <= strb;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 50);
    chk("bvalid", 32'h1, {31'h0, bvalid});
    chk("bresp", {30'h0, er}, {30'h0, bresp});
    bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input logic [1:0] er);
    int n;
    n = 0;
    araddr  <= {2'b00, idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 50);
    rd_q = rdata;
    chk("rvalid", 32'h1, {31'h0, rvalid});
    chk("rresp", {30'h0, er}, {30'h0, rresp});
    chk("rdata", {24'h0, exp}, rd_q);
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  task automatic stop_test;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset;
    rd(`RTC_IDX_ENSET, 8'h00, 2'b00);
    rd(`RTC_IDX_FLAG, 8'h00, 2'b00);
    rd(`RTC_IDX_STATUS, 8'h00, 2'b00);
    rd(`RTC_IDX_DEBUG, 8'h00, 2'b00);
    rd(`RTC_IDX_TRIM, 8'h00, 2'b00);
    rd(8'h3f, 8'h00, 2'b10);
    wr(8'h3f, 8'hff, 2'b10);
    wr(`RTC_IDX_STATUS, 8'hff, 2'b00);
    rd(`RTC_IDX_STATUS, 8'h00, 2'b00);
    // Byte 0 strobe low: the write is answered but has no effect
    strb = 4'he;
    wr(`RTC_IDX_DEBUG, 8'h01, 2'b00);
    strb = 4'hf;
    rd(`RTC_IDX_DEBUG, 8'h00, 2'b00);
    $display("test reset done");
  endtask : t_reset

  task automatic t_enables;
    mode_i <= RTC_COUNT16_MODE;
    wr(`RTC_IDX_ENSET, 8'h03, 2'b00);
    rd(`RTC_IDX_ENSET, 8'h03, 2'b00);
    wr(`RTC_IDX_ENSET, 8'h00, 2'b00);
    rd(`RTC_IDX_ENSET, 8'h03, 2'b00);
    wr(`RTC_IDX_ENCLR, 8'h01, 2'b00);
    rd(`RTC_IDX_ENSET, 8'h02, 2'b00);
    wr(`RTC_IDX_ENSET, 8'hff, 2'b00);
    rd(`RTC_IDX_ENSET, 8'hc3, 2'b00);
    mode_i <= RTC_CALENDAR_MODE;
    rd(`RTC_IDX_ENSET, 8'hc1, 2'b00);
    mode_i <= RTC_COUNT32_MODE;
    rd(`RTC_IDX_ENSET, 8'hc1, 2'b00);
    wr(`RTC_IDX_ENCLR, 8'hff, 2'b00);
    rd(`RTC_IDX_ENSET, 8'h00, 2'b00);
    $display("test enables done");
  endtask : t_enables

  task automatic t_event(input rtc_mode_t m, input rtc_evt_t ev, input logic [7:0] en,
                         input logic [7:0] exp);
    mode_i <= m;
    wr(`RTC_IDX_ENSET, en, 2'b00);
    events_i <= ev;
    repeat (DIV + 1) @(posedge aclk);
    events_i <= '0;
    repeat (2 * DIV + 2) @(posedge aclk);
    rd(`RTC_IDX_FLAG, exp, 2'b00);
    chk("irq", {31'h0, |(en & exp)}, {31'h0, irq_o});
    wr(`RTC_IDX_FLAG, 8'h00, 2'b00);
    rd(`RTC_IDX_FLAG, exp, 2'b00);
    wr(`RTC_IDX_FLAG, exp, 2'b00);
    rd(`RTC_IDX_FLAG, 8'h00, 2'b00);
    repeat (2) @(posedge aclk);
    chk("irq", 32'h0, {31'h0, irq_o});
    wr(`RTC_IDX_ENCLR, 8'hff, 2'b00);
    $display("test event mode %0d done", m);
  endtask : t_event

  task automatic t_sync;
    mode_i <= RTC_COUNT32_MODE;
    wr(`RTC_IDX_ENSET, 8'h40, 2'b00);
    sync_quiet_i <= 1'b0;
    sync_start_i <= 1'b1;
    @(posedge aclk);
    sync_start_i <= 1'b0;
    rd(`RTC_IDX_STATUS, 8'h80, 2'b00);
    repeat (8) @(posedge aclk);
    rd(`RTC_IDX_STATUS, 8'h00, 2'b00);
    rd(`RTC_IDX_FLAG, 8'h40, 2'b00);
    chk("irq", 32'h1, {31'h0, irq_o});
    wr(`RTC_IDX_FLAG, 8'h40, 2'b00);
    sync_quiet_i <= 1'b1;
    sync_start_i <= 1'b1;
    @(posedge aclk);
    sync_start_i <= 1'b0;
    repeat (10) @(posedge aclk);
    rd(`RTC_IDX_FLAG, 8'h00, 2'b00);
    wr(`RTC_IDX_ENCLR, 8'h40, 2'b00);
    $display("test sync done");
  endtask : t_sync

  task automatic t_trim(input logic [7:0] v, input int exp);
    int n, k;
    wr(`RTC_IDX_TRIM, v, 2'b00);
    rd(`RTC_IDX_TRIM, v, 2'b00);
    repeat (10) @(posedge aclk);
    do @(posedge aclk); while (counter_clock_o !== 1'b1);
    n = 0;
    k = 0;
    while (k < 128) begin
      @(posedge aclk);
      n++;
      if (counter_clock_o === 1'b1) k++;
    end
    chk("tick span", exp, n);
    $display("test trim %h done", v);
  endtask : t_trim

  task automatic t_debug;
    int n;
    wr(`RTC_IDX_DEBUG, 8'h01, 2'b00);
    wr(`RTC_IDX_TRIM, 8'h85, 2'b00);
    // Let the trim sync finish before the software reset
    repeat (4) @(posedge aclk);
    swrst_i <= 1'b1;
    @(posedge aclk);
    swrst_i <= 1'b0;
    repeat (2) @(posedge aclk);
    rd(`RTC_IDX_DEBUG, 8'h01, 2'b00);
    rd(`RTC_IDX_TRIM, 8'h00, 2'b00);
    dbg_halt_i <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      repeat (2) @(posedge aclk);
      n = 0;
      repeat (5 * DIV) begin
        @(posedge aclk);
        if (counter_clock_o === 1'b1) n++;
      end
      chk("ticks in debug", (p == 0) ? 5 : 0, n);
      wr(`RTC_IDX_DEBUG, 8'h00, 2'b00);
    end
    dbg_halt_i <= 1'b0;
    $display("test debug done");
  endtask : t_debug

  // ----------------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {swrst_i, sync_start_i, sync_quiet_i, dbg_halt_i} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    strb     = 4'hf;
    mode_i   = RTC_COUNT32_MODE;
    events_i = '0;
    errors   = 0;
    compares = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset();
    t_enables();
    t_event(RTC_COUNT16_MODE, '{1'b0, 2'b10, 1'b0}, 8'h02, 8'h02);
    t_event(RTC_COUNT32_MODE, '{1'b0, 2'b11, 1'b0}, 8'h01, 8'h01);
    t_event(RTC_CALENDAR_MODE, '{1'b1, 2'b00, 1'b1}, 8'h80, 8'h81);
    t_event(RTC_COUNT16_MODE, '{1'b1, 2'b00, 1'b0}, 8'h00, 8'h80);
    t_sync();
    t_trim(8'h00, 128 * DIV);
    t_trim(8'h05, 128 * DIV + 5);
    t_trim(8'h85, 128 * DIV - 5);
    t_debug();
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    $display("watchdog expired");
    stop_test();
  end

endmodule : rtc_irq_regs_tb
